// ==== design/adc_cfg_pkg.sv ====
// Package: register map, reset values, field positions and counts
// of the converter configuration bank.
// Assumes a serial port of 16 instruction bits then 8 data bits.
package adc_cfg_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [9:0] ADDR_CHANNEL_COUNT = 10'h001;
    localparam logic [9:0] ADDR_OUT_RATE = 10'h002;
    localparam logic [9:0] ADDR_SERIAL_TIMING = 10'h004;
    localparam logic [9:0] ADDR_RANDOMIZER = 10'h007;
    localparam logic [9:0] ADDR_CAL_DELAY = 10'h01E;
    localparam logic [9:0] ADDR_DELAY_LOOP = 10'h052;
    localparam logic [9:0] ADDR_CLOCK_SOURCE = 10'h053;
    localparam logic [9:0] ADDR_REFDIV_LOW = 10'h054;
    localparam logic [9:0] ADDR_OUTDIV_REFDIV = 10'h055;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CHANNEL_COUNT = 8'h0F;
    localparam logic [7:0] RST_OUT_RATE = 8'h00;
    localparam logic [7:0] RST_SERIAL_TIMING = 8'h9F;
    localparam logic [7:0] RST_RANDOMIZER = 8'h62;
    localparam logic [7:0] RST_CAL_DELAY = 8'h80;
    localparam logic [7:0] RST_DELAY_LOOP = 8'h0A;
    localparam logic [7:0] RST_CLOCK_SOURCE = 8'h45;
    localparam logic [7:0] RST_REFDIV_LOW = 8'h00;
    localparam logic [7:0] RST_OUTDIV_REFDIV = 8'h48;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int IND_RATE_BIT = 7;
    localparam int CHAN_SEL_LSB = 3;
    localparam int DATA_RATE_LSB = 4;
    localparam int CLOCK_RATE_LSB = 0;
    localparam int LAUNCH_EDGE_BIT = 7;
    localparam int WCLK_INV_BIT = 7;
    localparam int CAL_EN_BIT = 6;
    localparam int RAND_EN_BIT = 0;
    localparam int DUTY_BIT = 7;
    localparam int PHASE_LSB = 4;
    localparam int LOOP_CLK_OUT_BIT = 3;
    localparam int LOOP_EN_BIT = 2;
    localparam int CLK_BUF_BIT = 1;
    localparam int LOOP_RST_BIT = 0;
    localparam int SRC_SEL_BIT = 7;
    localparam int OUTDIV_LSB = 4;
    localparam int INSTR_READ_BIT = 15;

    // ----------------------------------------
    // Codes and counts
    // ----------------------------------------
    localparam logic [3:0] CHAN_EIGHT = 4'h8;
    localparam logic [3:0] RATE_TEST_MIN = 4'hA;
    localparam logic [3:0] RATE_ZERO_MIN = 4'hD;
    localparam logic [3:0] RATE_MAX_LOG2 = 4'h9;
    localparam logic [3:0] CLK_FULL = 4'hF;
    localparam logic [4:0] LAST_INSTR_BIT = 5'h0F;
    localparam logic [4:0] LAST_FRAME_BIT = 5'h17;
    localparam logic [7:0] CAL_STEP_CYCLES = 8'h10;

    typedef enum logic [0:0] {
        CAL_IDLE = 1'b0,
        CAL_WAIT = 1'b1
    } cal_state_t;

endpackage : adc_cfg_pkg

// ==== design/adc_cfg_regs.sv ====
// Configuration bank: serial port slave, register storage and the
// controls derived from it.
// Assumes serial pins already synchronous to clk and sclk far slower.
//
// Functional notes
// - channel field gives 1..7 inputs, zero means eight
// - data codes 1010..1111 force outputs zero
// - other data codes divide rate by powers two
// - clock rate nibble used only when independent
// - clock codes 1010..1110 stop data clock
// - launch edge bit picks falling or rising
// - word clock inverts when its bit set
// - calibration waits linear delay when enabled
// - randomizer bit enables output randomizing
// - duty correction bit enables correction
// - phase field shifts clock in 45 degree steps
// - phase applies only enabled and without decimation
// - cleared loop clock output kills converter output while loop enabled
// - loop enable bit turns on phase path
// - cleared clock buffer stops clocks and output
// - loop held in reset while bit zero
// - source bit zero selects external clock
// - output divider codes zero, one give none
// - standby stops most circuits, keeps registers
// - low-power reset stops output and clocks
module adc_cfg_regs #(
    parameter logic [7:0] CAL_STEP = adc_cfg_pkg::CAL_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic cal_request,
    input wire logic reference_divider_en,
    input wire logic phase_delay_en,
    input wire logic decimation_active,
    input wire logic standby,
    input wire logic low_power_reset,
    output logic [3:0] channel_count,
    output logic data_zero,
    output logic data_rate_en,
    output logic clock_rate_en,
    output logic data_clock_out_en,
    output logic word_clock_invert,
    output logic randomizer_en,
    output logic cal_start,
    output logic duty_correct_en,
    output logic [2:0] out_clock_phase_sel,
    output logic loop_clock_out_en,
    output logic loop_en,
    output logic loop_reset_n,
    output logic internal_clock_en,
    output logic converter_output_en,
    output logic pll_clock_sel,
    output logic [9:0] pll_reference_divider,
    output logic [3:0] pll_output_divider
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [8:0] rate_mask(input logic [3:0] code);
        logic [3:0] lg;
        lg = (code > adc_cfg_pkg::RATE_MAX_LOG2) ? 4'h0 : code;
        rate_mask = 9'((10'h001 << lg) - 10'h001);
    endfunction : rate_mask

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Serial port
    // ----------------------------------------
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [22:0] in_sh;
    logic [9:0] addr;
    logic read_phase;
    logic [7:0] out_sh;
    logic [7:0] channel_count_ctrl;
    logic [7:0] out_rate_ctrl;
    logic [7:0] serial_out_timing;
    logic [7:0] randomizer_wordclk_ctrl;
    logic [7:0] autocal_start_delay;
    logic [7:0] delay_loop_ctrl;
    logic [7:0] clock_source_select;
    logic [7:0] pll_reference_divider_low;
    logic [7:0] pll_output_divider_refdiv_high;

    wire rise = !cs_n && sclk && !sclk_q;
    wire fall = !cs_n && !sclk && sclk_q;
    wire [23:0] frame = {in_sh, sdi};
    wire instr_done = rise && bit_cnt == adc_cfg_pkg::LAST_INSTR_BIT;
    wire load_read = instr_done && frame[adc_cfg_pkg::INSTR_READ_BIT];
    wire write_done = rise && !read_phase && bit_cnt == adc_cfg_pkg::LAST_FRAME_BIT;
    wire launch_fall = serial_out_timing[adc_cfg_pkg::LAUNCH_EDGE_BIT];
    wire launch = read_phase && (launch_fall ? fall : rise);
    wire [9:0] frame_addr = frame[9:0];
    wire [7:0] wdata = frame[7:0];

    logic [7:0] rdata;
    always_comb
    begin
        unique case (frame_addr)
            adc_cfg_pkg::ADDR_CHANNEL_COUNT: rdata = channel_count_ctrl;
            adc_cfg_pkg::ADDR_OUT_RATE: rdata = out_rate_ctrl;
            adc_cfg_pkg::ADDR_SERIAL_TIMING: rdata = serial_out_timing;
            adc_cfg_pkg::ADDR_RANDOMIZER: rdata = randomizer_wordclk_ctrl;
            adc_cfg_pkg::ADDR_CAL_DELAY: rdata = autocal_start_delay;
            adc_cfg_pkg::ADDR_DELAY_LOOP: rdata = delay_loop_ctrl;
            adc_cfg_pkg::ADDR_CLOCK_SOURCE: rdata = clock_source_select;
            adc_cfg_pkg::ADDR_REFDIV_LOW: rdata = pll_reference_divider_low;
            adc_cfg_pkg::ADDR_OUTDIV_REFDIV: rdata = pll_output_divider_refdiv_high;
            default: rdata = adc_cfg_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 1'b0;
            bit_cnt <= 5'h00;
            in_sh <= 23'h000000;
            addr <= 10'h000;
            read_phase <= 1'b0;
            out_sh <= 8'h00;
            sdo <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk;
            if (cs_n)
            begin
                bit_cnt <= 5'h00;
                read_phase <= 1'b0;
            end
            else if (rise)
            begin
                in_sh <= frame[22:0];
                bit_cnt <= 5'(bit_cnt + 5'h01);
            end
            if (instr_done)
                addr <= frame_addr;
            // Rising launch puts the first bit out on the loading edge
            if (load_read && !launch_fall)
            begin
                read_phase <= 1'b1;
                sdo <= rdata[7];
                out_sh <= {rdata[6:0], 1'b0};
            end
            else if (load_read)
            begin
                read_phase <= 1'b1;
                out_sh <= rdata;
            end
            else if (launch)
            begin
                sdo <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    wire [9:0] waddr = addr;

    // Contents survive standby and low-power reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            channel_count_ctrl <= adc_cfg_pkg::RST_CHANNEL_COUNT;
            out_rate_ctrl <= adc_cfg_pkg::RST_OUT_RATE;
            serial_out_timing <= adc_cfg_pkg::RST_SERIAL_TIMING;
            randomizer_wordclk_ctrl <= adc_cfg_pkg::RST_RANDOMIZER;
            autocal_start_delay <= adc_cfg_pkg::RST_CAL_DELAY;
            delay_loop_ctrl <= adc_cfg_pkg::RST_DELAY_LOOP;
            clock_source_select <= adc_cfg_pkg::RST_CLOCK_SOURCE;
            pll_reference_divider_low <= adc_cfg_pkg::RST_REFDIV_LOW;
            pll_output_divider_refdiv_high <= adc_cfg_pkg::RST_OUTDIV_REFDIV;
        end
        else if (write_done)
        begin
            unique case (waddr)
                adc_cfg_pkg::ADDR_CHANNEL_COUNT: channel_count_ctrl <= wdata;
                adc_cfg_pkg::ADDR_OUT_RATE: out_rate_ctrl <= wdata;
                adc_cfg_pkg::ADDR_SERIAL_TIMING: serial_out_timing <= wdata;
                adc_cfg_pkg::ADDR_RANDOMIZER: randomizer_wordclk_ctrl <= wdata;
                adc_cfg_pkg::ADDR_CAL_DELAY: autocal_start_delay <= wdata;
                adc_cfg_pkg::ADDR_DELAY_LOOP: delay_loop_ctrl <= wdata;
                adc_cfg_pkg::ADDR_CLOCK_SOURCE: clock_source_select <= wdata;
                adc_cfg_pkg::ADDR_REFDIV_LOW: pll_reference_divider_low <= wdata;
                adc_cfg_pkg::ADDR_OUTDIV_REFDIV: pll_output_divider_refdiv_high <= wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Derived controls
    // ----------------------------------------
    wire [2:0] chan_sel = channel_count_ctrl[adc_cfg_pkg::CHAN_SEL_LSB +: 3];
    wire independent_rate_en = channel_count_ctrl[adc_cfg_pkg::IND_RATE_BIT];
    wire [3:0] output_data_rate_code = out_rate_ctrl[adc_cfg_pkg::DATA_RATE_LSB +: 4];
    wire [3:0] output_clock_rate_code = out_rate_ctrl[adc_cfg_pkg::CLOCK_RATE_LSB +: 4];
    wire next_data_zero = output_data_rate_code >= adc_cfg_pkg::RATE_TEST_MIN;
    wire [3:0] clk_code = independent_rate_en ? output_clock_rate_code
        : (next_data_zero ? adc_cfg_pkg::CLK_FULL : output_data_rate_code);
    wire clk_off = clk_code >= adc_cfg_pkg::RATE_TEST_MIN && clk_code != adc_cfg_pkg::CLK_FULL;
    wire [3:0] next_channel_count = (chan_sel == 3'h0) ? adc_cfg_pkg::CHAN_EIGHT
        : {1'b0, chan_sel};
    wire lp_off = standby || low_power_reset;
    wire clk_buf = delay_loop_ctrl[adc_cfg_pkg::CLK_BUF_BIT];
    wire next_loop_en = delay_loop_ctrl[adc_cfg_pkg::LOOP_EN_BIT];
    wire next_loop_clk_out = delay_loop_ctrl[adc_cfg_pkg::LOOP_CLK_OUT_BIT];
    wire next_int_clk = clk_buf && !lp_off;
    wire next_conv_out = next_int_clk && !(next_loop_en && !next_loop_clk_out);
    wire phase_ok = phase_delay_en && !decimation_active;
    wire [2:0] next_phase = phase_ok ? delay_loop_ctrl[adc_cfg_pkg::PHASE_LSB +: 3]
        : 3'h0;
    wire [3:0] out_div_code = pll_output_divider_refdiv_high[adc_cfg_pkg::OUTDIV_LSB +: 4];
    wire [3:0] next_out_div = (out_div_code <= 4'h1) ? 4'h1 : out_div_code;
    wire [9:0] ref_code = {pll_output_divider_refdiv_high[1:0], pll_reference_divider_low};
    wire [9:0] next_ref_div = (!reference_divider_en || ref_code <= 10'h001) ? 10'h001
        : ref_code;

    // Free divider shared by the data and clock rate strobes
    logic [8:0] div_cnt;
    wire next_data_en = next_int_clk && !next_data_zero
        && (div_cnt & rate_mask(output_data_rate_code)) == 9'h000;
    wire next_clock_en = next_int_clk && !clk_off
        && (div_cnt & rate_mask(clk_code)) == 9'h000;

    // ----------------------------------------
    // Calibration start delay
    // ----------------------------------------
    adc_cfg_pkg::cal_state_t cal_state;
    adc_cfg_pkg::cal_state_t next_cal_state;
    logic [15:0] cal_cnt;
    wire cal_en = randomizer_wordclk_ctrl[adc_cfg_pkg::CAL_EN_BIT];
    wire [15:0] cal_load = 16'({8'h00, autocal_start_delay} * {8'h00, CAL_STEP});
    wire cal_idle_go = cal_state == adc_cfg_pkg::CAL_IDLE && cal_request;
    wire cal_fire = (cal_idle_go && !cal_en)
        || (cal_state == adc_cfg_pkg::CAL_WAIT && cal_cnt == 16'h0000);

    always_comb
    begin
        next_cal_state = cal_state;
        unique case (cal_state)
            adc_cfg_pkg::CAL_IDLE:
                if (cal_request && cal_en)
                    next_cal_state = adc_cfg_pkg::CAL_WAIT;
            adc_cfg_pkg::CAL_WAIT:
                if (cal_cnt == 16'h0000)
                    next_cal_state = adc_cfg_pkg::CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_state <= adc_cfg_pkg::CAL_IDLE;
            cal_cnt <= 16'h0000;
            div_cnt <= 9'h000;
        end
        else
        begin
            cal_state <= next_cal_state;
            div_cnt <= 9'(div_cnt + 9'h001);
            if (cal_idle_go)
                cal_cnt <= cal_load;
            else if (cal_cnt != 16'h0000)
                cal_cnt <= 16'(cal_cnt - 16'h0001);
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdo_oe <= 1'b0;
            channel_count <= 4'h1;
            data_zero <= 1'b0;
            data_rate_en <= 1'b0;
            clock_rate_en <= 1'b0;
            data_clock_out_en <= 1'b0;
            word_clock_invert <= 1'b0;
            randomizer_en <= 1'b0;
            cal_start <= 1'b0;
            duty_correct_en <= 1'b0;
            out_clock_phase_sel <= 3'h0;
            loop_clock_out_en <= 1'b0;
            loop_en <= 1'b0;
            loop_reset_n <= 1'b0;
            internal_clock_en <= 1'b0;
            converter_output_en <= 1'b0;
            pll_clock_sel <= 1'b0;
            pll_reference_divider <= 10'h001;
            pll_output_divider <= 4'h1;
        end
        else
        begin
            sdo_oe <= !cs_n && (read_phase || load_read);
            channel_count <= next_channel_count;
            data_zero <= next_data_zero;
            data_rate_en <= next_data_en;
            clock_rate_en <= next_clock_en;
            data_clock_out_en <= next_int_clk && !clk_off;
            word_clock_invert <= randomizer_wordclk_ctrl[adc_cfg_pkg::WCLK_INV_BIT];
            randomizer_en <= randomizer_wordclk_ctrl[adc_cfg_pkg::RAND_EN_BIT];
            cal_start <= cal_fire;
            duty_correct_en <= delay_loop_ctrl[adc_cfg_pkg::DUTY_BIT];
            out_clock_phase_sel <= next_phase;
            loop_clock_out_en <= next_loop_clk_out;
            loop_en <= next_loop_en;
            loop_reset_n <= delay_loop_ctrl[adc_cfg_pkg::LOOP_RST_BIT];
            internal_clock_en <= next_int_clk;
            converter_output_en <= next_conv_out;
            pll_clock_sel <= clock_source_select[adc_cfg_pkg::SRC_SEL_BIT];
            pll_reference_divider <= next_ref_div;
            pll_output_divider <= next_out_div;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence cal_armed_s;
        cal_idle_go && cal_en && autocal_start_delay != 8'h00;
    endsequence
    sequence cal_quiet_s;
        !cal_start [*2];
    endsequence

    chan_eight_a: assert property (chan_sel == 3'h0 |=> channel_count == 4'h8)
        else $error("eight channels not decoded");
    data_zero_a: assert property (output_data_rate_code >= 4'hD |=> data_zero)
        else $error("data not forced to zero");
    rate_512_a: assert property (output_data_rate_code == 4'h9 && $stable(out_rate_ctrl)
        && data_rate_en |=> !data_rate_en [*8])
        else $error("divide by 512 strobe too frequent");
    clock_follow_a: assert property (!independent_rate_en && out_rate_ctrl == 8'h0B
        && next_int_clk |=> clock_rate_en)
        else $error("clock nibble used while not independent");
    clock_stop_a: assert property (independent_rate_en && output_clock_rate_code == 4'hA
        |=> !data_clock_out_en)
        else $error("data clock still driven");
    launch_edge_a: assert property (read_phase && launch_fall && $changed(sdo)
        |-> $past(fall))
        else $error("serial data launched on wrong edge");
    cal_delay_a: assert property (cal_armed_s |=> cal_quiet_s)
        else $error("calibration started without delay");
    cal_direct_a: assert property (cal_idle_go && !cal_en |=> cal_start)
        else $error("undelayed calibration missing");
    phase_gate_a: assert property (decimation_active |=> out_clock_phase_sel == 3'h0)
        else $error("phase applied during decimation");
    clock_buffer_a: assert property (!clk_buf |=> !converter_output_en
        && !internal_clock_en)
        else $error("output while clock buffer off");
    loop_reset_a: assert property (!delay_loop_ctrl[0] |=> !loop_reset_n)
        else $error("loop released from reset");
    low_power_a: assert property (lp_off |=> !converter_output_en
        && !data_rate_en)
        else $error("output during low power");

endmodule : adc_cfg_regs

// ==== tb/serial_host_model.sv ====
// Host side of the serial configuration port: 16 instruction bits, 8 data bits.
// Assumes the caller starts a transfer only between frames.
module serial_host_model #(
    parameter int HALF = 5
) (
    input wire logic clk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sclk = 1'h0;
        cs_n = 1'h1;
        sdi = 1'h0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Falling launch is read before each rise, rising launch before each fall
    task automatic xfer(input logic rd, input logic [9:0] addr, input logic [7:0] wd,
                        input logic fall_mode, output logic [7:0] rd_data);
        logic [23:0] frame;
        frame = {rd, 5'h00, addr, wd};
        rd_data = 8'h00;
        @(posedge clk);
        cs_n <= 1'h0;
        for (int i = 0; i < 24; i++)
        begin
            sdi <= frame[23 - i];
            idle(HALF);
            if (fall_mode && i >= 16)
                rd_data = {rd_data[6:0], sdo};
            sclk <= 1'h1;
            idle(HALF);
            if (!fall_mode && i >= 15 && i < 23)
                rd_data = {rd_data[6:0], sdo};
            sclk <= 1'h0;
        end
        idle(HALF);
        cs_n <= 1'h1;
        // Released line must not keep the last bit
        sdi <= ~sdi;
        idle(4);
    endtask : xfer
endmodule : serial_host_model

// ==== tb/test_adc_output_clock_config_regs.sv ====
// Self-checking bench for the configuration bank.
// Assumes the serial host model and a 20 MHz clock.
module test_adc_output_clock_config_regs;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] CAL_STEP_TB = 8'h02;
    localparam logic [9:0] ADDR_TAB [9] = '{10'h001, 10'h002, 10'h004, 10'h007, 10'h01E,
        10'h052, 10'h053, 10'h054, 10'h055};
    localparam logic [7:0] RST_TAB [9] = '{8'h0F, 8'h00, 8'h9F, 8'h62, 8'h80, 8'h0A,
        8'h45, 8'h00, 8'h48};
    localparam logic [7:0] MASK_TAB [9] = '{8'hB8, 8'hFF, 8'h80, 8'hC1, 8'hFF, 8'hFF,
        8'h80, 8'hFF, 8'hF3};
    logic clk, rstn, sclk, cs_n, sdi, sdo, sdo_oe, cal_request, reference_divider_en;
    logic phase_delay_en, decimation_active, standby, low_power_reset, data_zero;
    logic data_rate_en, clock_rate_en, data_clock_out_en, word_clock_invert, randomizer_en;
    logic cal_start, duty_correct_en, loop_clock_out_en, loop_en, loop_reset_n;
    logic internal_clock_en, converter_output_en, pll_clock_sel;
    logic [3:0] channel_count, pll_output_divider;
    logic [2:0] out_clock_phase_sel;
    logic [9:0] pll_reference_divider;
    logic [7:0] shadow [9];
    logic [7:0] rd;
    int fails, n_tests, seed, idx, a, b, z, n1, n2;

    adc_cfg_regs #(.CAL_STEP(CAL_STEP_TB)) i_dut (.clk, .rstn, .sclk, .cs_n, .sdi, .sdo,
        .sdo_oe, .cal_request, .reference_divider_en, .phase_delay_en, .decimation_active,
        .standby, .low_power_reset, .channel_count, .data_zero, .data_rate_en, .clock_rate_en,
        .data_clock_out_en, .word_clock_invert, .randomizer_en, .cal_start, .duty_correct_en,
        .out_clock_phase_sel, .loop_clock_out_en, .loop_en, .loop_reset_n, .internal_clock_en,
        .converter_output_en, .pll_clock_sel, .pll_reference_divider, .pll_output_divider);
    serial_host_model #(.HALF(5)) i_host (.clk, .sdo, .sclk, .cs_n, .sdi);

    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Factory bits kept, test rate codes and reference ratio two avoided
    function automatic logic [7:0] legal(input int i, input logic [7:0] v);
        logic [7:0] x;
        x = (v & MASK_TAB[i]) | (RST_TAB[i] & ~MASK_TAB[i]);
        if (i == 1 && x[7:4] inside {[4'hA:4'hC]})
            x[7:4] = 4'h0;
        if (i == 7 && x == 8'h02)
            x = 8'h03;
        return x;
    endfunction : legal

    task automatic wr(input int i, input logic [7:0] v);
        i_host.xfer(1'h0, ADDR_TAB[i], v, shadow[2][7], rd);
        shadow[i] = v;
    endtask : wr

    task automatic rd_chk(input int i);
        i_host.xfer(1'h1, ADDR_TAB[i], 8'h00, shadow[2][7], rd);
        check("register", shadow[i], rd);
    endtask : rd_chk

    task automatic check_ctrl;
        logic [7:0] c, r, l, h;
        logic [3:0] eff;
        logic [9:0] rv;
        logic [2:0] ph;
        @(negedge clk);
        c = shadow[0];
        r = shadow[1];
        l = shadow[5];
        h = shadow[8];
        eff = c[7] ? r[3:0] : (r[7:4] >= 4'hD ? 4'hF : r[7:4]);
        rv = reference_divider_en ? {h[1:0], shadow[7]} : 10'h001;
        ph = phase_delay_en && !decimation_active ? l[6:4] : 3'h0;
        check("sdo_oe", 1'h0, sdo_oe);
        check("channel_count", c[5:3] == 3'h0 ? 4'h8 : {1'h0, c[5:3]}, channel_count);
        check("data_zero", r[7:4] >= 4'hD, data_zero);
        check("data_clock_out_en", !(eff inside {[4'hA:4'hE]}) && l[1], data_clock_out_en);
        check("word_clock_invert", shadow[3][7], word_clock_invert);
        check("randomizer_en", shadow[3][0], randomizer_en);
        check("duty_correct_en", l[7], duty_correct_en);
        check("phase", ph, out_clock_phase_sel);
        check("loop_clock_out_en", l[3], loop_clock_out_en);
        check("loop_en", l[2], loop_en);
        check("converter_output_en", l[1] && !(l[2] && !l[3]), converter_output_en);
        check("internal_clock_en", l[1], internal_clock_en);
        check("loop_reset_n", l[0], loop_reset_n);
        check("pll_clock_sel", shadow[6][7], pll_clock_sel);
        check("pll_reference_divider", rv < 10'h002 ? 10'h001 : rv, pll_reference_divider);
        check("pll_output_divider", h[7:4] < 4'h2 ? 4'h1 : h[7:4], pll_output_divider);
    endtask : check_ctrl

    task automatic cal_lat(output int n);
        @(posedge clk);
        cal_request <= 1'h1;
        @(posedge clk);
        cal_request <= 1'h0;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (cal_start !== 1'h1 && n < 3000);
    endtask : cal_lat

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 32'h8EA8;
        fails = 0;
        n_tests = 0;
        rstn = 1'h0;
        cal_request = 1'h0;
        reference_divider_en = 1'h0;
        phase_delay_en = 1'h1;
        decimation_active = 1'h0;
        standby = 1'h0;
        low_power_reset = 1'h0;
        shadow = RST_TAB;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++)
            rd_chk(i);
        i_host.xfer(1'h0, 10'h003, 8'hA5, 1'h1, rd);
        i_host.xfer(1'h1, 10'h003, 8'h00, 1'h1, rd);
        check("unmapped", 8'h00, rd);
        for (int s = 0; s < 8; s++)
        begin
            wr(0, legal(0, {2'h2, 3'(s), 3'h0}));
            check_ctrl();
        end
        for (int c = 0; c < 16; c++)
        begin
            wr(1, legal(1, {4'(c), 4'(c)}));
            check_ctrl();
        end
        for (int d = 0; d < 10; d++)
        begin
            wr(1, {4'(d), 4'(d)});
            n1 = 0;
            n2 = 0;
            repeat (1024)
            begin
                @(negedge clk);
                n1 += (data_rate_en === 1'h1);
                n2 += (clock_rate_en === 1'h1);
            end
            check("data strobes", 11'(1024 >> d), 11'(n1));
            check("clock strobes", 11'(1024 >> d), 11'(n2));
        end
        wr(0, legal(0, 8'h08));
        wr(1, 8'h0B);
        check_ctrl();
        wr(2, 8'h1F);
        rd_chk(2);
        wr(2, 8'h9F);
        rd_chk(2);
        wr(4, 8'h02);
        cal_lat(a);
        wr(4, 8'h06);
        cal_lat(b);
        check("cal delay step", 11'(4 * CAL_STEP_TB), 11'(b - a));
        wr(3, legal(3, 8'h00));
        cal_lat(z);
        check("cal bypass", 1'h1, z < a);
        @(posedge clk);
        standby <= 1'h1;
        wr(4, 8'h5A);
        rd_chk(4);
        check("standby output", 1'h0, converter_output_en);
        standby <= 1'h0;
        low_power_reset <= 1'h1;
        repeat (3) @(negedge clk);
        check("lpr output", 1'h0, converter_output_en);
        check("lpr clocks", 1'h0, internal_clock_en);
        @(posedge clk);
        low_power_reset <= 1'h0;
        for (int k = 0; k < 40; k++)
        begin
            idx = $unsigned($random(seed)) % 9;
            @(posedge clk);
            phase_delay_en <= 1'($random(seed));
            decimation_active <= 1'($random(seed));
            reference_divider_en <= 1'($random(seed));
            wr(idx, legal(idx, 8'($random(seed))));
            check_ctrl();
            rd_chk(idx);
        end
        report_and_stop();
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule : test_adc_output_clock_config_regs
